// File: cstg_pkg.sv
package cstg_pkg;
  // ==========================================================
  // Master clock and divider ratios
  localparam int MASTER_HZ = 14318180;
  localparam int SUBCARRIER_DIV = 4;
  localparam int ELEMENT_DIV = 3;
  localparam int SYNC_REF_DIV = 7;
  localparam int REF_HIGH_CYC = 4;

  // ==========================================================
  // Element and injection counters
  localparam int ELEM_STAGES = 6;
  localparam int INJ_STAGES = 8;
  localparam logic [7:0] INJ_STOP = 8'h80;
  localparam int PAIR_NS = 420;
  localparam int PAIR_CYC = 2 * ELEMENT_DIV;
  localparam int EXT_BLANK_NS = 500;
  localparam int EXT_BLANK_CYC =
    int'((longint'(EXT_BLANK_NS) * longint'(MASTER_HZ)) / longint'(1000000000));

  // ==========================================================
  // Sync timing in reference ticks, 65 ticks per half line
  localparam int H_TICKS = 65;
  localparam int FP_START = 62;
  localparam int HSYNC_END = 10;
  localparam int BURST_START = 11;
  localparam int BURST_END = 16;
  localparam int KEY_END = 18;
  localparam int HDRIVE_END = 17;
  localparam int HBLANK_END = 19;
  localparam int EQ_END = 5;
  localparam int BROAD_END = 55;
  localparam int FIELD_HALF = 525;
  localparam int FRAME_HALF = 1050;
  localparam int EQ1_HL = 6;
  localparam int BROAD_HL_END = 12;
  localparam int VDRIVE_HL = 18;
  localparam int VBLANK_HL = 42;

  // ==========================================================
  // Line timing, lines counted from field restart
  localparam int TEST_LINE = 17;
  localparam int VSTART_LINE = 19;
  localparam int VRET_LAST = 21;
  localparam int ACTIVE_FIRST = 22;
  localparam int ACTIVE_LINES = 244;
endpackage

// File: cstg_elem_johnson.sv
module cstg_elem_johnson #(
  parameter int STAGES = cstg_pkg::ELEM_STAGES
) (
  // Master clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Per-line clear
  input wire logic line_clear_n,
  // Counter stages, stage 0 first
  output logic [STAGES-1:0] stages
);
  import cstg_pkg::*;

  localparam int HALF = STAGES / 2;

  if (STAGES < 4 || (STAGES % 2) != 0) begin : g_bad
    $error("STAGES must be even and at least four");
  end

  logic [HALF-1:0] even_q;
  logic [HALF-1:0] odd_q;

  // ==========================================================
  // Split clock: even stages on the rising edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      even_q <= '0;
    end else if (!line_clear_n) begin
      even_q <= '0;
    end else begin
      even_q <= {odd_q[HALF-2:0], ~odd_q[HALF-1]};
    end
  end

  // Odd stages on the falling edge, half-period resolution
  always_ff @(negedge core_clk or posedge rst) begin
    if (rst) begin
      odd_q <= '0;
    end else if (!line_clear_n) begin
      odd_q <= '0;
    end else begin
      odd_q <= even_q;
    end
  end

  always_comb begin
    for (int i = 0; i < HALF; i++) begin
      stages[2*i] = even_q[i];
      stages[2*i+1] = odd_q[i];
    end
  end
endmodule

// File: cstg_sync_gen.sv
module cstg_sync_gen (
  // Master clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Reference tick from the divide-by-seven
  input wire logic ref_en,
  // Standard timing, all registered
  output logic comp_sync_n,
  output logic hblank,
  output logic vblank,
  output logic horiz_drive_n,
  output logic vert_drive_n,
  output logic burst_flag,
  output logic key_clamp,
  // Strobes
  output logic line_start,
  output logic field_start
);
  import cstg_pkg::*;

  logic [6:0] tick_q;
  logic [10:0] half_q;
  logic [6:0] tick_d;
  logic [10:0] half_d;
  logic [10:0] fh;
  logic even_hl;
  logic eq_zone;
  logic broad_zone;
  logic vdrive;
  logic hsync;

  // ==========================================================
  // Tick and half-line counters
  always_comb begin
    tick_d = tick_q;
    half_d = half_q;
    if (ref_en) begin
      if (tick_q == 7'(H_TICKS - 1)) begin
        tick_d = '0;
        half_d = (half_q == 11'(FRAME_HALF - 1)) ? '0 : half_q + 11'h001;
      end else begin
        tick_d = tick_q + 7'h01;
      end
    end
    fh = (half_d >= 11'(FIELD_HALF)) ? half_d - 11'(FIELD_HALF) : half_d;
    even_hl = ~half_d[0];
    eq_zone = fh < 11'(EQ1_HL) || (fh >= 11'(BROAD_HL_END) && fh < 11'(VDRIVE_HL));
    broad_zone = fh >= 11'(EQ1_HL) && fh < 11'(BROAD_HL_END);
    vdrive = fh < 11'(VDRIVE_HL);
    hsync = even_hl && tick_d < 7'(HSYNC_END);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_q <= '0;
      half_q <= '0;
    end else begin
      tick_q <= tick_d;
      half_q <= half_d;
    end
  end

  // ==========================================================
  // Outputs from next state so they line up with the counters
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      comp_sync_n <= 1'h1;
      hblank <= 1'h0;
      vblank <= 1'h0;
      horiz_drive_n <= 1'h1;
      vert_drive_n <= 1'h1;
      burst_flag <= 1'h0;
      key_clamp <= 1'h0;
      line_start <= 1'h0;
      field_start <= 1'h0;
    end else begin
      if (eq_zone) begin
        comp_sync_n <= ~(tick_d < 7'(EQ_END));
      end else if (broad_zone) begin
        comp_sync_n <= ~(tick_d < 7'(BROAD_END));
      end else begin
        comp_sync_n <= ~hsync;
      end
      hblank <= (even_hl && tick_d < 7'(HBLANK_END)) || (!even_hl && tick_d >= 7'(FP_START));
      vblank <= fh < 11'(VBLANK_HL);
      horiz_drive_n <= ~((even_hl && tick_d < 7'(HDRIVE_END)) ||
                         (!even_hl && tick_d >= 7'(FP_START)));
      vert_drive_n <= ~vdrive;
      burst_flag <= even_hl && !vdrive && tick_d >= 7'(BURST_START) &&
                    tick_d < 7'(BURST_END);
      // Back porch only, inside blanking
      key_clamp <= even_hl && tick_d >= 7'(BURST_END) && tick_d < 7'(KEY_END);
      line_start <= ref_en && !even_hl && tick_d == 7'(FP_START);
      field_start <= ref_en && tick_d == '0 && fh == '0;
    end
  end
endmodule

// File: cstg_scan_timing.sv
// Functional notes
// - Master clock divided by four gives the colour subcarrier.
// - Master clock divided by three gives the element rate.
// - Divide-by-seven supplies the sync generator reference.
// - Sync generator gives composite sync, blanking, drives and burst flag.
// - Extended blank is composite blank with horizontal part lengthened half a microsecond.
// - Line clear restarts element counter and injection counter each line.
// - Element timing from six-stage Johnson counter with complemented feedback.
// - Element counter shifts ones then zeros, returning to cleared and repeating.
// - Even stages on true clock, odd on inverted clock.
// - Each element pulse is one two-input AND or NAND of stages.
// - Element counter changes one flip-flop per step, no glitches.
// - Injection Johnson counter runs fifteen steps then stops until line clear.
// - Each injection output is one two-input gate of the counter.
// - Line counter makes line-rate and once-per-retrace vertical signals.
// - Latch blocks retrace signals after the last one until next field.
// - Frame squarewave toggles on every burst flag; field read at restart.
// - Half-line squarewave changes only inside horizontal blanking.
// - Key clamp only inside horizontal blanking.
// - Test-line flag high through line 17; tone clock runs during it.
// - Horizontal phase clocks advance one column pair every 420 ns.
// - Even/odd select switches every 210 ns, away from sample and restore.
// - Column correction alternates on alternate element pairs.
module cstg_scan_timing (
  // Master clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Derived clocks
  output logic subcarrier_clk,
  output logic element_clk,
  output logic sync_ref_clk,
  // Standard television timing
  output logic comp_sync_n,
  output logic extended_blank_n,
  output logic horiz_drive_n,
  output logic vert_drive_n,
  output logic burst_flag,
  output logic key_clamp,
  // Line and field resets
  output logic line_clear_n,
  output logic field_restart,
  // Element rate timing
  output logic horiz_phase_a,
  output logic horiz_phase_b,
  output logic even_odd_select,
  output logic sample_pulse,
  output logic restore_pulse,
  output logic column_correction,
  // Injection timing
  output logic inject_col_zero,
  output logic column_reset,
  // Line timing
  output logic vert_enable_odd,
  output logic vert_enable_even,
  output logic vert_phase_a,
  output logic vert_phase_b,
  output logic vert_scan_start,
  output logic test_line_flag,
  output logic test_tone_clk,
  // Field reference squarewaves
  output logic frame_square,
  output logic half_line_square
);
  import cstg_pkg::*;

  // Window of a Johnson ring given as {~stages, stages}
  function automatic logic jpulse(input logic [15:0] ring, input int a, input int b);
    return ring[a] & ~ring[b];
  endfunction

  logic [1:0] sub_cnt_q;
  logic [1:0] elem_cnt_q;
  logic [2:0] ref_cnt_q;
  logic element_clk_q;
  logic sync_ref_clk_q;
  logic ref_en;
  logic ref_high;
  logic hblank;
  logic vblank;
  logic line_start;
  logic field_start;
  logic line_clear_n_q;
  logic field_restart_q;
  logic [ELEM_STAGES-1:0] elem_stages;
  logic [15:0] elem_ring;
  logic s0_prev_q;
  logic pair_tick;
  logic column_correction_q;
  logic [INJ_STAGES-1:0] inj_q;
  logic [15:0] inj_ring;
  logic inj_run;
  logic vert_win;
  logic phase_win;
  logic [9:0] line_q;
  logic vlatch_q;
  logic active_line;
  logic field_odd_q;
  logic frame_square_q;
  logic burst_prev_q;
  logic half_line_q;
  logic hblank_prev_q;
  logic [3:0] ext_cnt_q;
  logic ext_blank_n_q;
  logic vert_enable_odd_q;
  logic vert_enable_even_q;
  logic vert_phase_a_q;
  logic vert_phase_b_q;
  logic vert_scan_start_q;
  logic test_line_q;
  logic test_tone_q;

  // ==========================================================
  // Master clock dividers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sub_cnt_q <= '0;
    end else begin
      sub_cnt_q <= sub_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      elem_cnt_q <= '0;
      element_clk_q <= 1'h0;
    end else begin
      elem_cnt_q <= (elem_cnt_q == 2'(ELEMENT_DIV - 1)) ? '0 : elem_cnt_q + 2'h1;
      element_clk_q <= elem_cnt_q == 2'(ELEMENT_DIV - 1);
    end
  end

  assign ref_en = ref_cnt_q == 3'(SYNC_REF_DIV - 1);
  assign ref_high = ref_cnt_q < 3'(REF_HIGH_CYC);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_cnt_q <= '0;
      sync_ref_clk_q <= 1'h0;
    end else begin
      ref_cnt_q <= ref_en ? '0 : ref_cnt_q + 3'h1;
      sync_ref_clk_q <= ref_high;
    end
  end

  assign subcarrier_clk = sub_cnt_q[1];
  assign element_clk = element_clk_q;
  assign sync_ref_clk = sync_ref_clk_q;

  // ==========================================================
  // Sync generation
  cstg_sync_gen u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .ref_en(ref_en),
    .comp_sync_n(comp_sync_n),
    .hblank(hblank),
    .vblank(vblank),
    .horiz_drive_n(horiz_drive_n),
    .vert_drive_n(vert_drive_n),
    .burst_flag(burst_flag),
    .key_clamp(key_clamp),
    .line_start(line_start),
    .field_start(field_start)
  );

  // One-cycle line clear at start of blanking, field restart at vertical drive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_clear_n_q <= 1'h1;
      field_restart_q <= 1'h0;
    end else begin
      line_clear_n_q <= ~line_start;
      field_restart_q <= field_start;
    end
  end

  assign line_clear_n = line_clear_n_q;
  assign field_restart = field_restart_q;

  // Blanking stretched at its trailing edge to cover the sensor's active time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hblank_prev_q <= 1'h0;
      ext_cnt_q <= '0;
      ext_blank_n_q <= 1'h1;
    end else begin
      hblank_prev_q <= hblank;
      if (hblank_prev_q && !hblank) begin
        ext_cnt_q <= 4'(EXT_BLANK_CYC);
      end else if (ext_cnt_q != '0) begin
        ext_cnt_q <= ext_cnt_q - 4'h1;
      end
      ext_blank_n_q <= ~(vblank || hblank || hblank_prev_q || ext_cnt_q > 4'h1);
    end
  end

  assign extended_blank_n = ext_blank_n_q;

  // ==========================================================
  // Element scan logic
  cstg_elem_johnson #(
    .STAGES(ELEM_STAGES)
  ) u_elem (
    .core_clk(core_clk),
    .rst(rst),
    .line_clear_n(line_clear_n_q),
    .stages(elem_stages)
  );

  assign elem_ring = 16'({~elem_stages, elem_stages});

  // Single gates of stage outputs keep the decodes free of race glitches
  assign horiz_phase_a = jpulse(elem_ring, 0, 5);
  assign horiz_phase_b = jpulse(elem_ring, 6, 11);
  assign even_odd_select = jpulse(elem_ring, 1, 7);
  assign sample_pulse = jpulse(elem_ring, 4, 6);
  assign restore_pulse = jpulse(elem_ring, 10, 0);

  assign pair_tick = elem_stages[0] & ~s0_prev_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s0_prev_q <= 1'h0;
      column_correction_q <= 1'h0;
    end else begin
      s0_prev_q <= elem_stages[0];
      if (pair_tick) begin
        column_correction_q <= ~column_correction_q;
      end
    end
  end

  assign column_correction = column_correction_q;

  // ==========================================================
  // Injection logic, one run per line then parked
  assign inj_ring = 16'({~inj_q, inj_q});
  assign inj_run = ~jpulse(inj_ring, INJ_STAGES - 1, INJ_STAGES - 2);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inj_q <= INJ_STOP;
    end else if (!line_clear_n_q) begin
      inj_q <= '0;
    end else if (pair_tick && inj_run) begin
      inj_q <= {inj_q[INJ_STAGES-2:0], ~inj_q[INJ_STAGES-1]};
    end
  end

  assign inject_col_zero = jpulse(inj_ring, 3, 7);
  assign column_reset = jpulse(inj_ring, 8, 12);
  assign vert_win = jpulse(inj_ring, 0, 8);
  assign phase_win = jpulse(inj_ring, 9, 13);

  // ==========================================================
  // Line timing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // Reset starts on the first line, as a field restart does
      line_q <= 10'h001;
    end else if (field_restart_q) begin
      line_q <= 10'h001;
    end else if (line_start && line_q != '1) begin
      line_q <= line_q + 10'h001;
    end
  end

  // Set wins, so a late last line still blocks the next retrace
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vlatch_q <= 1'h0;
    end else if (line_start && line_q == 10'(VRET_LAST)) begin
      vlatch_q <= 1'h1;
    end else if (field_restart_q) begin
      vlatch_q <= 1'h0;
    end
  end

  assign active_line = line_q >= 10'(ACTIVE_FIRST) &&
                       line_q < 10'(ACTIVE_FIRST + ACTIVE_LINES);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vert_enable_odd_q <= 1'h0;
      vert_enable_even_q <= 1'h0;
      vert_phase_a_q <= 1'h0;
      vert_phase_b_q <= 1'h0;
    end else begin
      vert_enable_odd_q <= active_line && field_odd_q && vert_win;
      vert_enable_even_q <= active_line && !field_odd_q && vert_win;
      vert_phase_a_q <= active_line && !line_q[0] && phase_win;
      vert_phase_b_q <= active_line && line_q[0] && phase_win;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vert_scan_start_q <= 1'h0;
      test_line_q <= 1'h0;
      test_tone_q <= 1'h0;
    end else begin
      vert_scan_start_q <= !vlatch_q && line_q == 10'(VSTART_LINE) && vert_win;
      test_line_q <= !vlatch_q && line_q == 10'(TEST_LINE);
      // Reference divider square gives the roughly 2 MHz tone
      test_tone_q <= !vlatch_q && line_q == 10'(TEST_LINE) && ref_high;
    end
  end

  assign vert_enable_odd = vert_enable_odd_q;
  assign vert_enable_even = vert_enable_even_q;
  assign vert_phase_a = vert_phase_a_q;
  assign vert_phase_b = vert_phase_b_q;
  assign vert_scan_start = vert_scan_start_q;
  assign test_line_flag = test_line_q;
  assign test_tone_clk = test_tone_q;

  // ==========================================================
  // Field reference squarewaves
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      burst_prev_q <= 1'h0;
      frame_square_q <= 1'h0;
      field_odd_q <= 1'h0;
      half_line_q <= 1'h0;
    end else begin
      burst_prev_q <= burst_flag;
      if (burst_flag && !burst_prev_q) begin
        frame_square_q <= ~frame_square_q;
      end
      if (field_restart_q) begin
        field_odd_q <= frame_square_q;
      end
      if (line_start) begin
        half_line_q <= ~half_line_q;
      end
    end
  end

  assign frame_square = frame_square_q;
  assign half_line_square = half_line_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_subcarrier_period: assert property (
    $rose(subcarrier_clk) |-> ##4 $rose(subcarrier_clk))
    else $error("subcarrier period is not four clocks");
  chk_element_period: assert property (
    $rose(element_clk) |-> ##3 $rose(element_clk))
    else $error("element clock period is not three clocks");
  chk_sync_ref_period: assert property (
    $rose(sync_ref_clk) |-> ##7 $rose(sync_ref_clk))
    else $error("sync reference period is not seven clocks");
  chk_clear_restarts_counters: assert property (
    !line_clear_n |=> elem_stages == '0 && inj_q == '0)
    else $error("line clear did not restart the counters");
  chk_pair_period: assert property (
    pair_tick ##1 line_clear_n [*6] |-> pair_tick)
    else $error("element pair period is not six clocks");
  chk_single_step: assert property (
    line_clear_n && $past(line_clear_n) |->
      $countones(elem_stages ^ $past(elem_stages)) <= 2)
    else $error("element counter moved more than one stage per edge");
  chk_inject_parked: assert property (
    inj_q == INJ_STOP && line_clear_n |=> inj_q == INJ_STOP)
    else $error("injection counter left its final state");
  chk_key_in_blank: assert property (
    key_clamp |-> hblank)
    else $error("key clamp outside horizontal blanking");
  chk_half_line_blank: assert property (
    half_line_square != $past(half_line_square) |-> hblank)
    else $error("half-line squarewave changed outside blanking");
  chk_test_line_number: assert property (
    test_line_flag |-> $past(line_q) == 10'(TEST_LINE))
    else $error("test-line flag on the wrong line");
  chk_frame_toggle: assert property (
    $rose(burst_flag) |=> frame_square != $past(frame_square))
    else $error("frame squarewave missed a burst flag");
  chk_retrace_latch: assert property (
    $past(vlatch_q) && vlatch_q |-> !vert_scan_start && !test_line_flag)
    else $error("retrace signal while the latch is set");
endmodule

// File: cstg_preamp_model.sv
module cstg_preamp_model (
  // Master clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Scan timing seen by the sensor and preamplifier
  input wire logic line_clear_n,
  input wire logic horiz_phase_a,
  // Column pairs counted since the last line clear
  output logic [7:0] pairs_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase_q;

  // ==========================================================
  // Column pair counting
  // Counts saturate so a missing line clear cannot wrap silently
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_q <= 1'b0;
      pairs_seen <= 8'h00;
    end else begin
      phase_q <= horiz_phase_a;
      if (!line_clear_n) begin
        pairs_seen <= 8'h00;
      end else if (horiz_phase_a && !phase_q && pairs_seen != 8'hFF) begin
        pairs_seen <= pairs_seen + 8'h01;
      end
    end
  end
endmodule

// File: camera_scan_timing_generator_tb.sv
module camera_scan_timing_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cstg_pkg::*;
  logic core_clk, rst, subcarrier_clk, element_clk, sync_ref_clk, comp_sync_n;
  logic extended_blank_n, horiz_drive_n, vert_drive_n, burst_flag, key_clamp;
  logic line_clear_n, field_restart, horiz_phase_a, horiz_phase_b, even_odd_select;
  logic sample_pulse, restore_pulse, column_correction, inject_col_zero, column_reset;
  logic vert_enable_odd, vert_enable_even, vert_phase_a, vert_phase_b, vert_scan_start;
  logic test_line_flag, test_tone_clk, frame_square, half_line_square;
  logic [7:0] pairs_seen;
  int miscompares, checks;

  cstg_scan_timing cstg_scan_timing_inst (.core_clk, .rst, .subcarrier_clk, .element_clk,
    .sync_ref_clk, .comp_sync_n, .extended_blank_n, .horiz_drive_n, .vert_drive_n,
    .burst_flag, .key_clamp, .line_clear_n, .field_restart, .horiz_phase_a, .horiz_phase_b,
    .even_odd_select, .sample_pulse, .restore_pulse, .column_correction, .inject_col_zero,
    .column_reset, .vert_enable_odd, .vert_enable_even, .vert_phase_a, .vert_phase_b,
    .vert_scan_start, .test_line_flag, .test_tone_clk, .frame_square, .half_line_square);
  cstg_preamp_model cstg_preamp_model_inst (.core_clk, .rst, .line_clear_n, .horiz_phase_a,
    .pairs_seen);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ==========================================================
  // Shared helpers
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  // Bounded wait, a stuck signal ends the run
  task automatic wait_lvl(ref logic s, input logic lvl, input int bound);
    int n;
    n = 0;
    while (s !== lvl) begin
      tick();
      n++;
      if (n > bound) begin
        miscompares++;
        final_report();
      end
    end
  endtask

  task automatic period(ref logic s, output int hi, output int per);
    wait_lvl(s, 1'b0, 200);
    wait_lvl(s, 1'b1, 200);
    hi = 0;
    per = 0;
    while (s === 1'b1 && per < 200) begin
      tick();
      hi++;
      per++;
    end
    while (s !== 1'b1 && per < 200) begin
      tick();
      per++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_dividers();
    int h, p, sw, bad;
    logic prev;
    period(subcarrier_clk, h, p);
    check(p, SUBCARRIER_DIV);
    check(h, 2);
    period(element_clk, h, p);
    check(p, ELEMENT_DIV);
    check(h, 1);
    period(sync_ref_clk, h, p);
    check(p, SYNC_REF_DIV);
    check(h, REF_HIGH_CYC);
    period(horiz_phase_a, h, p);
    check(p, PAIR_CYC);
    period(column_correction, h, p);
    check(p, 2 * PAIR_CYC);
    // Select is watched on both edges since its stage 1 moves on the falling edge
    sw = 0;
    bad = 0;
    prev = even_odd_select;
    repeat (4 * PAIR_CYC) begin
      @(core_clk);
      #1;
      if (even_odd_select !== prev) begin
        sw++;
        if (sample_pulse === 1'b1 || restore_pulse === 1'b1) bad++;
      end
      prev = even_odd_select;
    end
    check(sw, 4);
    check(bad, 0);
    $display("test_dividers done");
  endtask

  task automatic test_lines();
    logic [5:0] pat, first_pat;
    int n, kc_bad, hl_bad, bf, fs, cr_early, cr_all;
    logic hl_q, bf_q, fs_q;
    wait_lvl(line_clear_n, 1'b0, 1000);
    hl_q = half_line_square;
    for (int ln = 0; ln < 3; ln++) begin
      n = 0;
      kc_bad = 0;
      hl_bad = 0;
      bf = 0;
      fs = 0;
      cr_early = 0;
      cr_all = 0;
      bf_q = burst_flag;
      fs_q = frame_square;
      tick();
      while (line_clear_n === 1'b1 && n < 2000) begin
        if (n < PAIR_CYC) pat[n] = horiz_phase_a;
        if (key_clamp === 1'b1 && extended_blank_n !== 1'b0) kc_bad++;
        if (half_line_square !== hl_q && extended_blank_n !== 1'b0) hl_bad++;
        if (burst_flag === 1'b1 && bf_q === 1'b0) bf++;
        if (frame_square !== fs_q) fs++;
        if (column_reset === 1'b1) cr_all++;
        if (column_reset === 1'b1 && n < 16 * PAIR_CYC) cr_early++;
        hl_q = half_line_square;
        bf_q = burst_flag;
        fs_q = frame_square;
        tick();
        n++;
      end
      if (ln == 0) first_pat = pat;
      // Toggle lands in the sample where line clear is low
      if (half_line_square !== hl_q && extended_blank_n !== 1'b0) hl_bad++;
      check(half_line_square !== hl_q, 1'b1);
      hl_q = half_line_square;
      check(n + 1, 910);
      check(pat, first_pat);
      check(kc_bad, 0);
      check(hl_bad, 0);
      check(fs, bf);
      check(cr_early, cr_all);
      check(cr_all, 4 * PAIR_CYC);
      check(cstg_preamp_model_inst.pairs_seen >= 8'd124, 1'b1);
    end
    $display("test_lines done");
  endtask

  task automatic test_field();
    int w, tg, late, hb, ecb, cs, hd, kc, ev, od, vp, icz, bf, fs;
    logic t_q, bf_q, fs_q;
    wait_lvl(test_line_flag, 1'b1, 25000);
    w = 0;
    tg = 0;
    t_q = test_tone_clk;
    while (test_line_flag === 1'b1 && w < 2000) begin
      if (test_tone_clk !== t_q) tg++;
      t_q = test_tone_clk;
      tick();
      w++;
    end
    check(w, 910);
    check(tg > 200, 1'b1);
    wait_lvl(vert_scan_start, 1'b1, 3 * 910);
    // First field after reset is even: the field flop is sampled only at restart
    wait_lvl(vert_enable_even, 1'b1, 6 * 910);
    late = 0;
    ecb = 0;
    cs = 0;
    hd = 0;
    kc = 0;
    ev = 0;
    od = 0;
    vp = 0;
    icz = 0;
    bf = 0;
    fs = 0;
    bf_q = burst_flag;
    fs_q = frame_square;
    hb = (H_TICKS - FP_START + HBLANK_END) * SYNC_REF_DIV;
    // Five whole active lines, so every periodic count is exact
    repeat (5 * 910) begin
      if (vert_scan_start === 1'b1 || test_line_flag === 1'b1) late++;
      if (extended_blank_n === 1'b0) ecb++;
      if (comp_sync_n === 1'b0) cs++;
      if (horiz_drive_n === 1'b0) hd++;
      if (key_clamp === 1'b1) kc++;
      if (vert_enable_even === 1'b1) ev++;
      if (vert_enable_odd === 1'b1) od++;
      if (vert_phase_a === 1'b1 || vert_phase_b === 1'b1) vp++;
      if (inject_col_zero === 1'b1) icz++;
      if (burst_flag === 1'b1 && bf_q === 1'b0) bf++;
      if (frame_square !== fs_q) fs++;
      bf_q = burst_flag;
      fs_q = frame_square;
      tick();
    end
    check(late, 0);
    check(ecb, 5 * (hb + EXT_BLANK_CYC));
    check(cs, 5 * HSYNC_END * SYNC_REF_DIV);
    check(hd, 5 * (HDRIVE_END + H_TICKS - FP_START) * SYNC_REF_DIV);
    check(kc, 5 * (KEY_END - BURST_END) * SYNC_REF_DIV);
    check(ev, 5 * INJ_STAGES * PAIR_CYC);
    check(od, 0);
    check(vp, 5 * 4 * PAIR_CYC);
    check(icz, 5 * 4 * PAIR_CYC);
    check(bf, 5);
    check(fs, bf);
    $display("test_field done");
  endtask

  initial begin
    rst = 1'b1;
    miscompares = 0;
    checks = 0;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    test_dividers();
    test_lines();
    test_field();
    final_report();
  end
endmodule
